// ### include/lsr_params.svh
// Register offsets, field positions, reset values and defaults of the light sensor register bank.
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

// Register offsets.
`define LSR_OFS_IRQ_FLAGS 8'h00
`define LSR_OFS_MAIN_SETUP 8'h01
`define LSR_OFS_UPPER_HI 8'h06
`define LSR_OFS_UPPER_LO 8'h07
`define LSR_OFS_LOWER_HI 8'h08
`define LSR_OFS_LOWER_LO 8'h09
`define LSR_OFS_PERSIST 8'h0A
`define LSR_OFS_PROXIMITY_CHANNEL_DIR 8'h0B
`define LSR_OFS_PROXIMITY_CHANNEL_LIMIT 8'h0C
`define LSR_OFS_GREEN_GAIN 8'h0F
`define LSR_OFS_IR_GAIN 8'h10

// Reset values.
`define LSR_RST_IRQ_FLAGS 3'h4
`define LSR_RST_MAIN_SETUP 6'h24
`define LSR_RST_THRESH 14'h0000
`define LSR_RST_PERSIST 4'h0
`define LSR_RST_PROXIMITY_CHANNEL_LIMIT 8'h00
`define LSR_RST_GAIN 8'h80

// Field positions.
`define LSR_BIT_AMB_FLAG 0
`define LSR_BIT_PROXIMITY_CHANNEL_FLAG 1
`define LSR_BIT_PWR_FLAG 2
`define LSR_BIT_AMB_IE 0
`define LSR_BIT_PROXIMITY_CHANNEL_IE 1
`define LSR_MODE_LSB 2
`define LSR_MODE_MSB 4
`define LSR_BIT_TRIM 5
`define LSR_BIT_PROXIMITY_CHANNEL_ABOVE 6

// Mode codes.
`define LSR_MODE_SHUTDOWN 3'h0
`define LSR_MODE_AMB_DIFF 3'h1
`define LSR_MODE_AMB_GREEN 3'h2
`define LSR_MODE_AMB_IR 3'h3
`define LSR_MODE_INTERLEAVE 3'h4
`define LSR_MODE_PROXIMITY_CHANNEL_ONLY 3'h5

`endif

// ### include/lsr_pkg.sv
// Types shared by the light sensor register bank.
package lsr_pkg;

  // One register access from the serial interface engine.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } lsr_reg_req_t;

  // One ambient conversion result.
  typedef struct packed {
    logic valid;
    logic overflow;
    logic [13:0] value;
  } lsr_amb_sample_t;

  // One proximity conversion result.
  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } lsr_proximity_channel_sample_t;

  // Source of the ambient result.
  typedef enum logic [1:0] {
    LSR_SRC_DIFF,
    LSR_SRC_GREEN,
    LSR_SRC_IR
  } lsr_src_t;

endpackage

// ### design/lsr_persist.sv
// Consecutive-hit filter that fires once a condition outlasts a persist count.
module lsr_persist #(
  parameter int CW = 2
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Samples.
  input wire logic enable,
  input wire logic sample_valid,
  input wire logic hit,
  input wire logic [CW-1:0] limit,
  // Result.
  output logic fire_q
);
  import lsr_pkg::*;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic fire_d;

  // Count earlier consecutive hits, saturating at the limit; fire when they reach it.
  assign cnt_d = (!enable || !hit) ? '0 : ((cnt_q < limit) ? cnt_q + 1'b1 : cnt_q);
  assign fire_d = enable && sample_valid && hit && (cnt_q >= limit);

  // A disabled filter forgets its history so a re-enable starts fresh.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      fire_q <= 1'b0;
    end else begin
      if (sample_valid || !enable) begin
        cnt_q <= cnt_d;
      end
      fire_q <= fire_d;
    end
  end

endmodule

// ### design/lsr_regs.sv
// Interrupt flags, mode decoder and gain source select of the light sensor register bank.
`include "lsr_params.svh"

module lsr_regs #(
  parameter bit FIRST_REV = 1'b0,
  parameter logic [7:0] FACTORY_GREEN_GAIN = 8'h80,
  parameter logic [7:0] FACTORY_IR_GAIN = 8'h80,
  parameter int PERSIST_W = 2
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register access from the serial engine.
  input wire lsr_pkg::lsr_reg_req_t reg_req,
  output logic [7:0] rd_data_q,
  // Conversion results.
  input wire lsr_pkg::lsr_amb_sample_t amb_sample,
  input wire lsr_pkg::lsr_proximity_channel_sample_t proximity_channel_sample,
  // Measurement control.
  output logic analog_en_q,
  output logic amb_conv_en_q,
  output logic proximity_channel_conv_en_q,
  output logic interleave_q,
  output lsr_pkg::lsr_src_t amb_src_q,
  output logic [7:0] green_gain_q,
  output logic [7:0] ir_gain_q,
  // Open-drain interrupt pin.
  output logic int_pin_o_q,
  output logic int_pin_oe_q
);
  import lsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic amb_flag_q;
  logic proximity_channel_flag_q;
  logic pwr_flag_q;
  logic [5:0] setup_q;
  logic [13:0] upper_q;
  logic [13:0] lower_q;
  logic [3:0] persist_q;
  logic proximity_channel_above_q;
  logic [7:0] proximity_channel_limit_q;
  logic [7:0] user_green_q;
  logic [7:0] user_ir_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // One write strobe per register except the flag register.
  wire wr_setup = reg_req.wr && (reg_req.addr == `LSR_OFS_MAIN_SETUP);
  wire wr_up_hi = reg_req.wr && (reg_req.addr == `LSR_OFS_UPPER_HI);
  wire wr_up_lo = reg_req.wr && (reg_req.addr == `LSR_OFS_UPPER_LO);
  wire wr_lo_hi = reg_req.wr && (reg_req.addr == `LSR_OFS_LOWER_HI);
  wire wr_lo_lo = reg_req.wr && (reg_req.addr == `LSR_OFS_LOWER_LO);
  wire wr_persist = reg_req.wr && (reg_req.addr == `LSR_OFS_PERSIST);
  wire wr_dir = reg_req.wr && (reg_req.addr == `LSR_OFS_PROXIMITY_CHANNEL_DIR);
  wire wr_limit = reg_req.wr && (reg_req.addr == `LSR_OFS_PROXIMITY_CHANNEL_LIMIT);
  wire wr_green = reg_req.wr && (reg_req.addr == `LSR_OFS_GREEN_GAIN);
  wire wr_ir = reg_req.wr && (reg_req.addr == `LSR_OFS_IR_GAIN);
  // Reading the flag register is what clears it.
  wire rd_flags = reg_req.rd && (reg_req.addr == `LSR_OFS_IRQ_FLAGS);

  // Next value of the setup register, used so that enable writes act at once.
  wire [5:0] setup_d = wr_setup ? reg_req.wdata[5:0] : setup_q;
  wire amb_ie_q = setup_q[`LSR_BIT_AMB_IE];
  wire proximity_channel_ie_q = setup_q[`LSR_BIT_PROXIMITY_CHANNEL_IE];
  wire amb_ie_d = setup_d[`LSR_BIT_AMB_IE];
  wire proximity_channel_ie_d = setup_d[`LSR_BIT_PROXIMITY_CHANNEL_IE];
  wire [2:0] mode_q = setup_q[`LSR_MODE_MSB:`LSR_MODE_LSB];
  wire trim_sel_q = setup_q[`LSR_BIT_TRIM];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoder.

  // Reserved codes decode to nothing, so they behave as shutdown.
  wire mode_amb = (mode_q == `LSR_MODE_AMB_DIFF) || (mode_q == `LSR_MODE_AMB_GREEN) ||
                  (mode_q == `LSR_MODE_AMB_IR) || (mode_q == `LSR_MODE_INTERLEAVE);
  wire mode_proximity_channel = (mode_q == `LSR_MODE_INTERLEAVE) ||
                   (mode_q == `LSR_MODE_PROXIMITY_CHANNEL_ONLY);
  wire mode_run = mode_amb || mode_proximity_channel;
  wire mode_both = (mode_q == `LSR_MODE_INTERLEAVE);
  lsr_src_t src_d;
  assign src_d = (mode_q == `LSR_MODE_AMB_GREEN) ? LSR_SRC_GREEN :
                 (mode_q == `LSR_MODE_AMB_IR) ? LSR_SRC_IR : LSR_SRC_DIFF;

  ////////////////////////////////////////////////////////////////////////////
  // Threshold comparison.

  // Samples only count while the mode updates that result and the enable is on.
  wire amb_eval = mode_amb && amb_ie_q;
  wire proximity_channel_eval = mode_proximity_channel && proximity_channel_ie_q;
  wire amb_hit = (amb_sample.value > upper_q) || (amb_sample.value < lower_q);
  wire proximity_channel_hit = proximity_channel_sample.value > proximity_channel_limit_q;
  logic amb_fire;
  logic proximity_channel_fire;

  lsr_persist #(
    .CW(PERSIST_W)
  ) u_amb_persist (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(amb_eval),
    .sample_valid(amb_sample.valid),
    .hit(amb_hit),
    .limit(persist_q[PERSIST_W-1:0]),
    .fire_q(amb_fire)
  );

  lsr_persist #(
    .CW(PERSIST_W)
  ) u_proximity_channel_persist (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(proximity_channel_eval),
    .sample_valid(proximity_channel_sample.valid),
    .hit(proximity_channel_hit),
    .limit(persist_q[2*PERSIST_W-1:PERSIST_W]),
    .fire_q(proximity_channel_fire)
  );

  // An overflow sets the ambient flag without waiting for the persist count.
  wire amb_set = amb_fire || (amb_eval && amb_sample.valid && amb_sample.overflow);
  wire proximity_channel_set = proximity_channel_fire && proximity_channel_ie_q;

  ////////////////////////////////////////////////////////////////////////////
  // Flag update; a set in the clearing cycle wins over the read clear.

  wire amb_flag_d = amb_ie_d && (amb_set || (amb_flag_q && !rd_flags));
  wire proximity_channel_flag_d = proximity_channel_ie_d && (proximity_channel_set || (proximity_channel_flag_q && !rd_flags));
  wire pwr_flag_d = pwr_flag_q && !rd_flags;
  wire pwr_drives = pwr_flag_d && !FIRST_REV;
  wire int_d = amb_flag_d || proximity_channel_flag_d || pwr_drives;

  // Flag read data is captured before the clear takes effect.
  wire [7:0] rd_mux =
    (reg_req.addr == `LSR_OFS_IRQ_FLAGS) ? {5'h00, pwr_flag_q, proximity_channel_flag_q, amb_flag_q} :
    (reg_req.addr == `LSR_OFS_MAIN_SETUP) ? {2'h0, setup_q} :
    (reg_req.addr == `LSR_OFS_UPPER_HI) ? {2'h0, upper_q[13:8]} :
    (reg_req.addr == `LSR_OFS_UPPER_LO) ? upper_q[7:0] :
    (reg_req.addr == `LSR_OFS_LOWER_HI) ? {2'h0, lower_q[13:8]} :
    (reg_req.addr == `LSR_OFS_LOWER_LO) ? lower_q[7:0] :
    (reg_req.addr == `LSR_OFS_PERSIST) ? {4'h0, persist_q} :
    (reg_req.addr == `LSR_OFS_PROXIMITY_CHANNEL_DIR) ? {1'b0, proximity_channel_above_q, 6'h00} :
    (reg_req.addr == `LSR_OFS_PROXIMITY_CHANNEL_LIMIT) ? proximity_channel_limit_q :
    (reg_req.addr == `LSR_OFS_GREEN_GAIN) ? user_green_q :
    (reg_req.addr == `LSR_OFS_IR_GAIN) ? user_ir_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt pin.

  // Power-on reset loads the power-up flag; the pin only ever pulls low.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {pwr_flag_q, proximity_channel_flag_q, amb_flag_q} <= `LSR_RST_IRQ_FLAGS;
      int_pin_oe_q <= !FIRST_REV;
      int_pin_o_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      amb_flag_q <= amb_flag_d;
      proximity_channel_flag_q <= proximity_channel_flag_d;
      pwr_flag_q <= pwr_flag_d;
      int_pin_oe_q <= int_d;
      int_pin_o_q <= 1'b0;
      if (reg_req.rd) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and threshold registers.

  // Every power-up event returns thresholds and setup to their defaults.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      setup_q <= `LSR_RST_MAIN_SETUP;
      upper_q <= `LSR_RST_THRESH;
      lower_q <= `LSR_RST_THRESH;
      persist_q <= `LSR_RST_PERSIST;
      proximity_channel_above_q <= 1'b0;
      proximity_channel_limit_q <= `LSR_RST_PROXIMITY_CHANNEL_LIMIT;
    end else begin
      setup_q <= setup_d;
      if (wr_up_hi) upper_q[13:8] <= reg_req.wdata[5:0];
      if (wr_up_lo) upper_q[7:0] <= reg_req.wdata;
      if (wr_lo_hi) lower_q[13:8] <= reg_req.wdata[5:0];
      if (wr_lo_lo) lower_q[7:0] <= reg_req.wdata;
      if (wr_persist) persist_q <= reg_req.wdata[3:0];
      if (wr_dir) proximity_channel_above_q <= reg_req.wdata[`LSR_BIT_PROXIMITY_CHANNEL_ABOVE];
      if (wr_limit) proximity_channel_limit_q <= reg_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain trim registers and measurement control outputs.

  // User gain bytes are kept even while the factory gains are selected.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      user_green_q <= `LSR_RST_GAIN;
      user_ir_q <= `LSR_RST_GAIN;
      green_gain_q <= FACTORY_GREEN_GAIN;
      ir_gain_q <= FACTORY_IR_GAIN;
      analog_en_q <= 1'b0;
      amb_conv_en_q <= 1'b0;
      proximity_channel_conv_en_q <= 1'b0;
      interleave_q <= 1'b0;
      amb_src_q <= LSR_SRC_DIFF;
    end else begin
      if (wr_green) user_green_q <= reg_req.wdata;
      if (wr_ir) user_ir_q <= reg_req.wdata;
      green_gain_q <= trim_sel_q ? FACTORY_GREEN_GAIN : user_green_q;
      ir_gain_q <= trim_sel_q ? FACTORY_IR_GAIN : user_ir_q;
      analog_en_q <= mode_run;
      amb_conv_en_q <= mode_amb;
      proximity_channel_conv_en_q <= mode_proximity_channel;
      interleave_q <= mode_both;
      amb_src_q <= src_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_flag_read;
    reg_req.rd && (reg_req.addr == `LSR_OFS_IRQ_FLAGS);
  endsequence

  // Pin follows the flags, with the power-up flag excluded in the first revision.
  a_int_pin_level: assert property (
    int_pin_oe_q == (amb_flag_q || proximity_channel_flag_q || (pwr_flag_q && !FIRST_REV)))
    else $error("interrupt pin does not match flags");

  a_read_returns_flags: assert property (
    s_flag_read |=> rd_data_q == {5'h00, $past(pwr_flag_q), $past(proximity_channel_flag_q),
                                  $past(amb_flag_q)})
    else $error("flag read returned wrong data");

  a_read_clears_flags: assert property (
    s_flag_read ##0 (!amb_set && !proximity_channel_set) |=> !amb_flag_q && !proximity_channel_flag_q && !pwr_flag_q)
    else $error("flag read did not clear flags");

  a_disable_holds_zero: assert property (
    (!amb_ie_q |-> !amb_flag_q) and (!proximity_channel_ie_q |-> !proximity_channel_flag_q))
    else $error("flag set while its enable is off");

  a_pwr_flag_sticky: assert property (
    pwr_flag_q && !rd_flags |=> pwr_flag_q)
    else $error("power-up flag cleared without a read");

  a_amb_flag_sets: assert property (
    amb_set && amb_ie_q && !wr_setup |=> amb_flag_q)
    else $error("ambient event did not set flag");

  a_proximity_channel_flag_sets: assert property (
    proximity_channel_set && !wr_setup |=> proximity_channel_flag_q ##0 int_pin_oe_q)
    else $error("proximity event did not set flag and pin");

  a_shutdown_stops: assert property (
    !mode_amb && !mode_proximity_channel && !wr_setup |=> ##1 (!analog_en_q && !amb_conv_en_q &&
    !proximity_channel_conv_en_q))
    else $error("conversions run in shutdown");

  a_proximity_channel_only_mode: assert property (
    (mode_q == `LSR_MODE_PROXIMITY_CHANNEL_ONLY) |=> proximity_channel_conv_en_q && !amb_conv_en_q)
    else $error("proximity-only mode wrong");

  a_gain_source: assert property (
    trim_sel_q |=> green_gain_q == FACTORY_GREEN_GAIN && ir_gain_q == FACTORY_IR_GAIN)
    else $error("factory gains not applied");

endmodule

// ### tb/lsr_host_model.sv
// Host-side model that reaches the register bank with single-cycle access strobes.
module lsr_host_model (
  // Clock.
  input wire logic core_clk,
  // Register access towards the bank.
  output lsr_pkg::lsr_reg_req_t reg_req
);
  timeunit 1ns;
  timeprecision 100ps;
  import lsr_pkg::*;

  // Idle bus at time zero.
  initial begin
    reg_req = '0;
  end

  // One access: held from just after an edge until the taking edge, then released.
  // Released address and data are inverted so that stale values are never trusted.
  task automatic access(input logic [7:0] addr, input logic is_wr, input logic [7:0] data);
    @(posedge core_clk);
    #1;
    reg_req.addr = addr;
    reg_req.wr = is_wr;
    reg_req.rd = !is_wr;
    reg_req.wdata = data;
    @(posedge core_clk);
    #1;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    reg_req.addr = ~addr;
    reg_req.wdata = ~data;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench of the light sensor register bank.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lsr_pkg::*;

  logic core_clk;
  logic sys_rst;
  lsr_reg_req_t req;
  lsr_amb_sample_t amb;
  lsr_proximity_channel_sample_t proximity_channel;
  logic [7:0] rd_data;
  logic analog_en, amb_en, proximity_channel_en, il;
  lsr_src_t src;
  logic [5:0] mode_seen;
  assign mode_seen = {analog_en, amb_en, proximity_channel_en, il, src};
  logic [7:0] g_gain, i_gain, g, ir;
  logic pin_o, pin_oe, pin_oe_r1;
  logic rd_d1 = 1'b0;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int n_tests = 0;
  int seed = 98288;

  ////////////////////////////////////////////////////////////////////////////////
  // Host model, bank under test and a first-revision bank on the same inputs.
  lsr_host_model u_host (.core_clk(core_clk), .reg_req(req));
  lsr_regs #(.FACTORY_GREEN_GAIN(8'h3C), .FACTORY_IR_GAIN(8'hC3)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(req), .rd_data_q(rd_data),
    .amb_sample(amb), .proximity_channel_sample(proximity_channel), .analog_en_q(analog_en), .amb_conv_en_q(amb_en),
    .proximity_channel_conv_en_q(proximity_channel_en), .interleave_q(il), .amb_src_q(src), .green_gain_q(g_gain),
    .ir_gain_q(i_gain), .int_pin_o_q(pin_o), .int_pin_oe_q(pin_oe));
  lsr_regs #(.FIRST_REV(1'b1)) u_dut_r1 (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(req), .rd_data_q(),
    .amb_sample(amb), .proximity_channel_sample(proximity_channel), .analog_en_q(), .amb_conv_en_q(),
    .proximity_channel_conv_en_q(), .interleave_q(), .amb_src_q(), .green_gain_q(),
    .ir_gain_q(), .int_pin_o_q(), .int_pin_oe_q(pin_oe_r1));

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Holds reset for eight edges, released just after an edge.
  task automatic do_reset();
    @(posedge core_clk);
    #1;
    sys_rst = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
  endtask

  // Lets a fixed number of edges pass and steps off the edge.
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Register write and read; a read notes its expected data first.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.access(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.access(a, 1'b0, 8'h00);
  endtask

  // One conversion result pulse on the ambient or the proximity input.
  task automatic smp(input logic is_proximity_channel, input logic [13:0] v, input logic ambient_overflow);
    @(posedge core_clk);
    #1;
    amb = {!is_proximity_channel, ambient_overflow, v};
    proximity_channel = {is_proximity_channel, v[7:0]};
    @(posedge core_clk);
    #1;
    amb = {1'b0, ~ambient_overflow, ~v};
    proximity_channel = {1'b0, ~v[7:0]};
  endtask

  // Expected measurement controls for a mode code.
  function automatic logic [5:0] mode_exp(input logic [2:0] m);
    case (m)
      3'h1: return {4'b1100, LSR_SRC_DIFF};
      3'h2: return {4'b1100, LSR_SRC_GREEN};
      3'h3: return {4'b1100, LSR_SRC_IR};
      3'h4: return {4'b1111, LSR_SRC_DIFF};
      3'h5: return {4'b1010, LSR_SRC_DIFF};
      default: return {4'b0000, LSR_SRC_DIFF};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Takes the oldest expected read value when read data appears.
  always @(posedge core_clk) begin
    if (rd_d1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected_read", 8'h01, 8'h00);
      end else begin
        chk("rd_data", rd_data, exp_q.pop_front());
      end
    end
    rd_d1 <= req.rd;
  end

  // Cuts a hang short.
  initial begin
    #300000;
    fail_count++;
    complete_run();
  end

  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    amb = '0;
    proximity_channel = '0;
    do_reset();
    chk("pin_oe", pin_oe, 8'h01);
    chk("pin_oe_rev1", pin_oe_r1, 8'h00);
    chk("pin_data", pin_o, 8'h00);
    rd(8'h01, 8'h24);
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h0F, 8'h80);
    rd(8'h10, 8'h80);
    rd(8'h20, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h04);
    rd(8'h00, 8'h00);
    settle(1);
    chk("pin_oe_cleared", pin_oe, 8'h00);
    // Every mode code, reserved ones included.
    for (int m = 0; m < 8; m++) begin
      wr(8'h01, {3'b001, m[2:0], 2'b00});
      rd(8'h01, {3'b001, m[2:0], 2'b00});
      chk("mode_outs", {2'b00, mode_seen}, {2'b00, mode_exp(m[2:0])});
    end
    // User gains with the select low, factory gains with it high.
    g = 8'($random(seed));
    ir = 8'($random(seed));
    wr(8'h0F, g);
    wr(8'h10, ir);
    wr(8'h01, 8'h04);
    settle(2);
    chk("green_gain", g_gain, g);
    chk("ir_gain", i_gain, ir);
    rd(8'h0F, g);
    wr(8'h01, 8'h24);
    settle(2);
    chk("green_factory", g_gain, 8'h3C);
    chk("ir_factory", i_gain, 8'hC3);
    // Ambient window 4..16 with one extra hit of persistence, mode 001.
    wr(8'h0A, 8'h05);
    wr(8'h07, 8'h10);
    wr(8'h09, 8'h04);
    wr(8'h01, 8'h07);
    smp(1'b1, 14'h00FF, 1'b0);
    smp(1'b1, 14'h00FF, 1'b0);
    smp(1'b0, 14'h0020, 1'b0);
    settle(2);
    chk("pin_oe_persist", pin_oe, 8'h00);
    smp(1'b0, 14'h0002, 1'b0);
    settle(2);
    chk("pin_oe_amb", pin_oe, 8'h01);
    chk("pin_oe_rev1_amb", pin_oe_r1, 8'h01);
    rd(8'h00, 8'h01);
    settle(1);
    chk("pin_oe_read", pin_oe, 8'h00);
    smp(1'b0, 14'h0008, 1'b1);
    settle(1);
    chk("pin_oe_ovf", pin_oe, 8'h01);
    wr(8'h01, 8'h04);
    settle(2);
    chk("pin_oe_ie_off", pin_oe, 8'h00);
    smp(1'b0, 14'h0020, 1'b1);
    smp(1'b0, 14'h0020, 1'b0);
    rd(8'h00, 8'h00);
    // Proximity only: ambient hits ignored, a miss restarts the count.
    wr(8'h0C, 8'h40);
    wr(8'h01, 8'h17);
    smp(1'b0, 14'h0020, 1'b1);
    smp(1'b1, 14'h0041, 1'b0);
    smp(1'b1, 14'h0040, 1'b0);
    smp(1'b1, 14'h0041, 1'b0);
    settle(2);
    chk("pin_oe_miss", pin_oe, 8'h00);
    smp(1'b1, 14'h0041, 1'b0);
    settle(2);
    chk("pin_oe_proximity_channel", pin_oe, 8'h01);
    rd(8'h00, 8'h02);
    // A second power-up restores thresholds and the power-up flag.
    do_reset();
    rd(8'h0C, 8'h00);
    rd(8'h0A, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h00, 8'h04);
    settle(2);
    complete_run();
  end
endmodule
